// file: rtl/adc_acq_conv_sequencer.sv
// Acquisition and conversion sequencer for a 10-bit successive-approximation converter
// Function
// (RULE_01) Power-on reset leaves both result bytes unmodified; contents unknown until a conversion.
// (RULE_02) Software must acquire the channel for the minimum time before converting.
// (RULE_03) Software waits three bit periods after a conversion before the next acquisition.
// (RULE_04) With zero acquisition code, go stops sampling at once and converts. With the RC clock the code keeps sampling through ST_DELAY.
// (RULE_05) Nonzero acquisition code keeps sampling the chosen bit periods, then converts.
// (RULE_06) Completion clears go, sets done flag, and resumes sampling the selected channel.
// (RULE_07) No status distinguishes acquisition end or conversion start; go stays set.
// (RULE_08) Each conversion takes eleven bit periods of the selected clock.
// (RULE_09) Clock code picks 2,4,8,16,32,64 oscillator periods or the RC clock.
// (RULE_10) Zero acquisition with RC clock delays conversion start one instruction cycle.
// (RULE_11) Software must select the RC clock to convert during Sleep.
// (RULE_12) Software clears idle and clock-select bits before a Sleep conversion.
// (RULE_13) Device clock source stays unchanged until the conversion completes.
// (RULE_14) Software should pick the RC clock below one megahertz.
// (RULE_15) Conversion ignores channel and direction settings; driven outputs convert their own level. The code converts the channel_sel pin.
// (RULE_16) Port reads return zero on analog pins; digital inputs still convert.
// (RULE_17) Software starts by setting go and polls it or uses the interrupt.
// (RULE_18) Acquisition codes map to 0,2,4,6,8,12,16,20 bit periods.
// (RULE_19) Clearing go mid-conversion aborts and keeps the last result.
// (RULE_20) Device reset turns the converter off and aborts any conversion.
// (RULE_21) Justify select one right-justifies the result; zero left-justifies it.
`timescale 1ns/1ps
`include "adc_seq_defs.svh"
module adc_acq_conv_sequencer #(
  parameter int RC_DIV   = `RC_DIV_DEFAULT,
  parameter int CHANNELS = `CHANNELS
) (
  input  wire logic                        clock,
  input  wire logic                        reset_n,
  input  wire adc_seq_pkg::conv_cfg_t      cfg,
  input  wire logic                        go_set,
  input  wire logic                        go_clear,
  input  wire logic                        done_flag_clear,
  input  wire logic                        result_write,
  input  wire adc_seq_pkg::conv_result_t   result_wdata,
  input  wire logic [3:0]                  port_cfg,
  input  wire logic [CHANNELS-1:0]         pin_in,
  input  wire logic [CHANNELS-1:0]         pin_out_level,
  input  wire logic [CHANNELS-1:0]         pin_direction_bits,
  input  wire logic [CHANNELS-1:0]         analog_compare_hi,
  output logic                             conv_go_flag,
  output logic                             conv_done_irq_flag,
  output logic                             sampling,
  output logic                             sar_trial,
  output logic [`RESULT_W-1:0]             sar_code,
  output adc_seq_pkg::conv_result_t        result,
  output logic [CHANNELS-1:0]              port_read
);
  // Divider and pin logic are sized for these ranges
  if (RC_DIV < 2 || RC_DIV > 65536) begin : g_bad_rc_div
    $error("RC divider out of range");
  end
  if (CHANNELS != 12) begin : g_bad_channels
    $error("Channel count must be twelve");
  end

  adc_seq_pkg::seq_state_t state_reg, state_next;
  logic [6:0]              div_reg;
  logic [15:0]             rc_div_reg;
  logic [`ACQ_CNT_W-1:0]   acq_cnt_reg;
  logic [`CONV_BITS_W-1:0] bit_cnt_reg;
  logic [1:0]              dly_cnt_reg;
  logic [`RESULT_W-1:0]    sar_reg;
  logic                    go_reg;
  logic                    done_reg;
  adc_seq_pkg::conv_result_t result_reg;

  // Oscillator periods in one bit period for each clock code
  function automatic logic [6:0] osc_div(input logic [2:0] code);
    case (code)
      3'b000:  osc_div = 7'd2;
      3'b100:  osc_div = 7'd4;
      3'b001:  osc_div = 7'd8;
      3'b101:  osc_div = 7'd16;
      3'b010:  osc_div = 7'd32;
      3'b110:  osc_div = 7'd64;
      default: osc_div = 7'd2;
    endcase
  endfunction

  // Bit periods of programmed acquisition for each code
  function automatic logic [`ACQ_CNT_W-1:0] acq_periods(input logic [2:0] code);
    case (code)
      3'd0:    acq_periods = 5'd0;
      3'd1:    acq_periods = 5'd2;
      3'd2:    acq_periods = 5'd4;
      3'd3:    acq_periods = 5'd6;
      3'd4:    acq_periods = 5'd8;
      3'd5:    acq_periods = 5'd12;
      3'd6:    acq_periods = 5'd16;
      default: acq_periods = 5'd20;
    endcase
  endfunction

  // Bit-period tick: oscillator divider or the RC divider
  wire       rc_sel     = (cfg.conv_clk_sel[1:0] == 2'b11); // RULE_09
  wire [6:0] div_max    = osc_div(cfg.conv_clk_sel) - 7'd1; // RULE_09
  wire       osc_tick   = (div_reg == div_max);
  wire       rc_tick    = (rc_div_reg == 16'(RC_DIV - 1));
  wire       tad_tick   = rc_sel ? rc_tick : osc_tick;
  // Both dividers restart with each acquisition or conversion so the first bit period is whole
  wire       tad_run    = (state_reg == adc_seq_pkg::ST_ACQ) || (state_reg == adc_seq_pkg::ST_CONVERT);
  wire       running    = (state_reg == adc_seq_pkg::ST_ACQ) || (state_reg == adc_seq_pkg::ST_DELAY)
                          || (state_reg == adc_seq_pkg::ST_CONVERT);
  // A cleared go only matters while a run is in progress
  wire       abort      = go_clear && running; // RULE_19
  wire       conv_last  = (state_reg == adc_seq_pkg::ST_CONVERT) && tad_tick
                          && (bit_cnt_reg == `CONV_BITS - 4'd1); // RULE_08
  wire       start      = go_set && cfg.converter_on && (state_reg == adc_seq_pkg::ST_SAMPLE);
  wire       acq_zero   = (cfg.acq_time_sel == 3'd0);
  wire       acq_done   = (state_reg == adc_seq_pkg::ST_ACQ) && tad_tick
                          && (acq_cnt_reg == acq_periods(cfg.acq_time_sel) - 5'd1);
  wire       dly_done   = (state_reg == adc_seq_pkg::ST_DELAY)
                          && (dly_cnt_reg == 2'(`INSTR_CYCLE_OSC - 1));
  wire [9:0] trial_bit  = 10'h200 >> bit_cnt_reg;
  wire [9:0] sar_trial_code = sar_reg | trial_bit;
  // Compare of the selected pin, whatever its direction or analog setting
  wire       cmp_hi     = analog_compare_hi[cfg.channel_sel] ; // RULE_15

  // Sample, then optional acquisition or start delay, then eleven bit periods
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      adc_seq_pkg::ST_OFF:     if (cfg.converter_on) state_next = adc_seq_pkg::ST_SAMPLE;
      adc_seq_pkg::ST_SAMPLE:  if (start) begin
        if (!acq_zero) state_next = adc_seq_pkg::ST_ACQ; // RULE_05
        else if (rc_sel) state_next = adc_seq_pkg::ST_DELAY; // RULE_10
        else state_next = adc_seq_pkg::ST_CONVERT; // RULE_04
      end
      adc_seq_pkg::ST_ACQ:     if (acq_done) state_next = adc_seq_pkg::ST_CONVERT; // RULE_05 RULE_07
      adc_seq_pkg::ST_DELAY:   if (dly_done) state_next = adc_seq_pkg::ST_CONVERT; // RULE_10
      adc_seq_pkg::ST_CONVERT: if (conv_last) state_next = adc_seq_pkg::ST_SAMPLE; // RULE_06
      default:                 state_next = adc_seq_pkg::ST_OFF;
    endcase
    if (abort) state_next = adc_seq_pkg::ST_SAMPLE; // RULE_19
    if (!cfg.converter_on) state_next = adc_seq_pkg::ST_OFF;
  end

  // A reset turns the converter off and drops any run
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) state_reg <= adc_seq_pkg::ST_OFF; // RULE_20
    else state_reg <= state_next;
  end

  // Go flag stands through acquisition, delay and conversion alike
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) go_reg <= 1'b0; // RULE_20
    else if (start) go_reg <= 1'b1;
    else if (conv_last || abort || !cfg.converter_on) go_reg <= 1'b0; // RULE_06 RULE_07
  end

  // Done flag: hardware set wins over software clear
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) done_reg <= 1'b0;
    else if (conv_last) done_reg <= 1'b1; // RULE_06
    else if (done_flag_clear) done_reg <= 1'b0;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      div_reg    <= 7'd0;
      rc_div_reg <= 16'd0;
    end else begin
      div_reg    <= (osc_tick || !tad_run) ? 7'd0 : div_reg + 7'd1;
      rc_div_reg <= (rc_tick || !tad_run) ? 16'd0 : rc_div_reg + 16'd1;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      acq_cnt_reg <= '0;
      bit_cnt_reg <= '0;
      dly_cnt_reg <= '0;
      sar_reg     <= '0;
    end else begin
      if (state_reg != adc_seq_pkg::ST_ACQ) acq_cnt_reg <= '0;
      else if (tad_tick) acq_cnt_reg <= acq_cnt_reg + 5'd1; // RULE_18
      dly_cnt_reg <= (state_reg == adc_seq_pkg::ST_DELAY) ? dly_cnt_reg + 2'd1 : 2'd0;
      if (state_reg != adc_seq_pkg::ST_CONVERT) begin
        bit_cnt_reg <= '0;
        sar_reg     <= '0;
      end else if (tad_tick) begin
        bit_cnt_reg <= bit_cnt_reg + 4'd1; // RULE_08
        // Trial bit kept while the input is not below the trial code
        if (bit_cnt_reg < 4'd10 && !cmp_hi) sar_reg <= sar_trial_code;
      end
    end
  end

  // Result bytes have no reset so a power-on leaves them untouched
  always_ff @(posedge clock) begin // RULE_01
    if (conv_last) begin
      if (cfg.result_justify_sel) result_reg <= {6'h00, sar_reg}; // RULE_21
      else result_reg <= {sar_reg, 6'h00}; // RULE_21
    end else if (result_write) begin
      result_reg <= result_wdata; // RULE_19
    end
  end

  // Analog pins read as zero; digital pins read their level
  // Codes below four leave every pin analog; each code above adds one digital pin from the top
  wire [3:0]  digital_shift = (port_cfg < 4'd4) ? 4'd12 : 4'd15 - port_cfg;
  wire [11:0] digital_mask  = 12'hFFF << digital_shift;
  wire [11:0] analog_mask   = ~digital_mask;
  wire [11:0] pin_level    = (pin_direction_bits & pin_in) | (~pin_direction_bits & pin_out_level);
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) port_read <= '0;
    else port_read <= pin_level & ~analog_mask; // RULE_16
  end

  assign conv_go_flag       = go_reg; // RULE_07
  assign conv_done_irq_flag = done_reg;
  // Sampling stands in the sample, acquisition and delay states, not while off
  assign sampling           = (state_reg == adc_seq_pkg::ST_SAMPLE) || (state_reg == adc_seq_pkg::ST_ACQ)
                              || (state_reg == adc_seq_pkg::ST_DELAY);
  assign sar_trial          = (state_reg == adc_seq_pkg::ST_CONVERT) && (bit_cnt_reg < 4'd10);
  assign sar_code           = sar_trial_code;
  assign result             = result_reg;
endmodule

// file: rtl/adc_seq_defs.svh
// Constants for the converter sequencer
`ifndef ADC_SEQ_DEFS_SVH
`define ADC_SEQ_DEFS_SVH
`define CONV_BITS          4'd11
`define CONV_BITS_W        4
`define ACQ_CNT_W          5
`define RC_DIV_DEFAULT     80
`define OSC_CYCLE_NS       50
`define INSTR_CYCLE_OSC    4
`define RESULT_W           10
`define CHANNELS           12
`endif

// file: rtl/adc_seq_pkg.sv
// Types for the converter sequencer
package adc_seq_pkg;
  typedef enum logic [4:0] {
    ST_OFF     = 5'b0_0001,
    ST_SAMPLE  = 5'b0_0010,
    ST_DELAY   = 5'b0_0100,
    ST_ACQ     = 5'b0_1000,
    ST_CONVERT = 5'b1_0000
  } seq_state_t;

  typedef struct packed {
    logic       result_justify_sel;
    logic [2:0] acq_time_sel;
    logic [2:0] conv_clk_sel;
    logic [3:0] channel_sel;
    logic       converter_on;
  } conv_cfg_t;

  typedef struct packed {
    logic [7:0] result_high_byte;
    logic [7:0] result_low_byte;
  } conv_result_t;
endpackage

// file: tb/adc_seq_chk.sv
// Concurrent checks on the sequencer ports
`timescale 1ns/1ps
module adc_seq_chk #(
  parameter int RC_DIV = 80
) (
  input wire logic                      clock,
  input wire logic                      reset_n,
  input wire adc_seq_pkg::conv_cfg_t    cfg,
  input wire logic                      go_set,
  input wire logic                      go_clear,
  input wire logic                      done_flag_clear,
  input wire logic                      result_write,
  input wire logic [3:0]                port_cfg,
  input wire logic                      conv_go_flag,
  input wire logic                      conv_done_irq_flag,
  input wire logic                      sampling,
  input wire adc_seq_pkg::conv_result_t result,
  input wire logic [11:0]               port_read
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  logic [15:0] cnt_reg;
  wire         rc      = (cfg.conv_clk_sel[1:0] == 2'b11);
  wire  [15:0] div     = rc ? 16'(RC_DIV) : 16'h0002 << ({cfg.conv_clk_sel[1:0], 1'b0} + cfg.conv_clk_sel[2]);
  wire  [4:0]  acq     = cfg.acq_time_sel[2] ? 5'h08 + {cfg.acq_time_sel[1:0], 2'b00} : {cfg.acq_time_sel[1:0], 1'b0};
  wire  [15:0] exp_len = (16'(acq) + 16'h000b) * div + ((rc && acq == 5'h00) ? 16'h0004 : 16'h0000);
  wire  [11:0] amask   = 12'hfff >> ((port_cfg < 4'h4) ? 4'h0 : port_cfg - 4'h3);
  // Cycles the go flag has stood without a break
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) cnt_reg <= 16'h0000;
    else cnt_reg <= conv_go_flag ? cnt_reg + 16'h0001 : 16'h0000;
  end
  a_go_taken: assert property (go_set && cfg.converter_on && sampling && !go_clear |=> conv_go_flag)
    else $error("go request not taken");
  a_conv_length: assert property ($rose(conv_done_irq_flag) |->
    cnt_reg + 16'h0002 >= exp_len && cnt_reg <= exp_len + 16'h0001)
    else $error("conversion length wrong");
  a_zero_acq_hold: assert property (conv_go_flag && cfg.acq_time_sel == 3'b000 && !rc |-> !sampling)
    else $error("sampling during zero-acquisition run");
  a_acq_sampling: assert property ($rose(conv_go_flag) && cfg.acq_time_sel != 3'b000 |-> sampling)
    else $error("no sampling in programmed acquisition");
  a_done_resample: assert property ($rose(conv_done_irq_flag) && cfg.converter_on |->
    !conv_go_flag && sampling)
    else $error("completion did not clear go and resample");
  a_done_holds: assert property (conv_done_irq_flag && !done_flag_clear |=> conv_done_irq_flag)
    else $error("done flag dropped");
  a_abort_keeps: assert property (go_clear && conv_go_flag && !result_write |=>
    !conv_go_flag && result == $past(result))
    else $error("abort changed result or left go set");
  a_justify_fmt: assert property ($rose(conv_done_irq_flag) |->
    (cfg.result_justify_sel ? result[15:10] == 6'h00 : result[5:0] == 6'h00))
    else $error("result justification wrong");
  a_port_analog: assert property (1'b1 |=> (port_read & $past(amask)) == 12'h000)
    else $error("analog pin read not zero");
  cover property ($rose(conv_done_irq_flag));
  cover property (go_clear && conv_go_flag);
  cover property ($rose(conv_go_flag) && rc);
endmodule
bind adc_acq_conv_sequencer adc_seq_chk #(.RC_DIV(RC_DIV)) chk_u (.clock, .reset_n, .cfg, .go_set, .go_clear,
  .done_flag_clear, .result_write, .port_cfg, .conv_go_flag, .conv_done_irq_flag, .sampling, .result, .port_read);

// file: tb/analog_src_model.sv
// Analog source model driving the per-pin comparators
`timescale 1ns/1ps
module analog_src_model (
  input  wire logic [9:0]  level,
  input  wire logic [9:0]  sar_code,
  output logic      [11:0] analog_compare_hi
);
  // Every pin carries one level, so the code is the same whatever channel or direction
  assign analog_compare_hi = {12{level < sar_code}};
endmodule

// file: tb/adc_acq_conv_sequencer_test.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
module adc_acq_conv_sequencer_test;
  logic                       clock = 1'b0, reset_n = 1'b0, go_set = 1'b0, go_clear = 1'b0;
  logic                       done_flag_clear = 1'b0, result_write = 1'b0;
  adc_seq_pkg::conv_cfg_t     cfg = '0;
  adc_seq_pkg::conv_result_t  result_wdata = 16'h0000, result;
  logic [3:0]                 port_cfg = 4'h0;
  logic [11:0]                pin_in = 12'h000, analog_compare_hi, port_read;
  logic [11:0]                pin_dir = 12'hfff, pin_out = 12'h000;
  logic                       conv_go_flag, conv_done_irq_flag, sampling, sar_trial;
  logic [9:0]                 sar_code, level = 10'h000;
  int                         err_total = 0, compares = 0, n;
  logic [16:0]                rows [8] = '{{3'b000, 3'b000, 1'b1, 10'h3ff}, {3'b100, 3'b001, 1'b0, 10'h001},
    {3'b001, 3'b111, 1'b1, 10'h200}, {3'b101, 3'b101, 1'b0, 10'h155}, {3'b010, 3'b010, 1'b1, 10'h0aa},
    {3'b110, 3'b011, 1'b0, 10'h2a5}, {3'b011, 3'b000, 1'b1, 10'h123}, {3'b111, 3'b100, 1'b0, 10'h3c0}};
  always #25 clock = ~clock;
  adc_acq_conv_sequencer #(.RC_DIV(6)) dut_u (.clock, .reset_n, .cfg, .go_set, .go_clear, .done_flag_clear,
    .result_write, .result_wdata, .port_cfg, .pin_in, .pin_out_level(pin_out), .pin_direction_bits(pin_dir),
    .analog_compare_hi, .conv_go_flag, .conv_done_irq_flag, .sampling, .sar_trial, .sar_code, .result, .port_read);
  analog_src_model src_u (.level, .sar_code, .analog_compare_hi);
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic pulse(ref logic s);
    @(negedge clock) s = 1'b1;
    @(negedge clock) s = 1'b0;
  endtask
  function automatic int exp_len(logic [2:0] c, logic [2:0] a);
    int d, q;
    d = (c[1:0] == 2'b11) ? 6 : 2 << (c[2] + 2 * c[1:0]);
    q = a[2] ? 8 + 4 * a[1:0] : 2 * a[1:0];
    return (q + 11) * d + ((d == 6 && q == 0) ? 4 : 0);
  endfunction
  initial begin
    repeat (3) @(negedge clock);
    chk("go_in_reset", conv_go_flag, 16'h0000);
    chk("done_in_reset", conv_done_irq_flag, 16'h0000);
    reset_n = 1'b1;
    cfg.converter_on = 1'b1;
    foreach (rows[i]) begin
      {cfg.conv_clk_sel, cfg.acq_time_sel, cfg.result_justify_sel, level} = rows[i];
      cfg.channel_sel = 4'(i);
      pin_dir = (i % 2 == 1) ? 12'h000 : 12'hfff;
      // Three bit periods of the slowest clock before the next start
      repeat (200) @(negedge clock);
      // Clock code x11 rows stand for Sleep conversions: RC clock, no clock source change
      pulse(go_set);
      n = 1;
      while (conv_go_flag === 1'b1 && n < 3000) begin
        @(negedge clock);
        n++;
      end
      chk("run_length", 16'(n + 2 >= exp_len(cfg.conv_clk_sel, cfg.acq_time_sel)
        && n <= exp_len(cfg.conv_clk_sel, cfg.acq_time_sel) + 1), 16'h0001);
      chk("result", result, cfg.result_justify_sel ? {6'h00, level} : {level, 6'h00});
      chk("done_set", conv_done_irq_flag, 16'h0001);
      pulse(done_flag_clear);
      chk("done_cleared", conv_done_irq_flag, 16'h0000);
    end
    result_wdata = 16'habcd;
    pulse(result_write);
    pulse(go_set);
    repeat (20) @(negedge clock);
    pulse(go_set);
    chk("go_kept", conv_go_flag, 16'h0001);
    pulse(go_clear);
    chk("go_aborted", conv_go_flag, 16'h0000);
    chk("result_kept", result, 16'habcd);
    chk("no_done_on_abort", conv_done_irq_flag, 16'h0000);
    pin_in = 12'hfff;
    for (int i = 0; i < 4; i++) begin
      port_cfg = (i == 0) ? 4'h0 : (i == 1) ? 4'h7 : 4'hf;
      pin_dir = (i == 3) ? 12'h0f0 : 12'hfff;
      pin_out = (i == 3) ? 12'h00f : 12'h000;
      repeat (2) @(negedge clock);
      chk("port_read", 16'(port_read),
        (i == 0) ? 16'h0000 : (i == 1) ? 16'h0f00 : (i == 2) ? 16'h0fff : 16'h00ff);
    end
    repeat (10) @(negedge clock);
    pulse(go_set);
    repeat (5) @(negedge clock);
    chk("sampling_in_acq", sampling, 16'h0001);
    chk("no_trial_in_acq", sar_trial, 16'h0000);
    reset_n = 1'b0;
    #1;
    chk("go_reset_abort", conv_go_flag, 16'h0000);
    @(negedge clock) reset_n = 1'b1;
    @(negedge clock);
    chk("sampling_after_reset", sampling, 16'h0001);
    chk("go_after_reset", conv_go_flag, 16'h0000);
    report_and_stop;
  end
  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    report_and_stop;
  end
endmodule
